/* hdl/lmcr_pkg.sv */
// Package with register map, field positions and reset values of the mission register set.
// Summary of operation
// - Conversions during a mission are spaced by the sample interval in minutes, 1 to 255.
// - Nonzero interval write starts a mission when memory is wiped and arm bit is 0.
// - A control register write while a mission runs ends it and updates contents.
// - Control byte bits: 7 osc stop, 6 wipe, 4 arm, 3 wrap, 2..0 searches.
// - Control bit 5 always reads 0 and cannot be set.
// - Oscillator runs when osc stop is 0; at 1 it halts and enters retention.
// - Mission start refused until the clock advanced one second after oscillator enable.
// - Wipe happens only if wipe enable is 1 and Clear Memory is the next access.
// - Wipe enable returns to 0 when the next memory function command executes.
// - Mission may begin on interval write only while arm bit reads 0.
// - With log wrap at 1, logging restarts at log start when memory is full.
// - With log wrap 0 and log full, storing stops but mission and histogram continue.
// - Cold search enabled answers Conditional Search if a sample was at or below low threshold.
// - Hot search enabled answers Conditional Search if a sample was at or above high threshold.
// - Timer alarm search answers Conditional Search on timer alarm; hosts should leave it 0.
// - Logging waits the 16-bit start delay in minutes; low byte 212h, high byte 213h.
// - Status byte at 214h: idle, wiped, mission, sample, cold, hot, timer flags.
// - Mission, cold, hot and timer flags can only be cleared by writes; others read-only.
// - Low threshold is a full byte at 20Bh, high threshold at 20Ch.
// - Wiped flag sets on Clear Memory and clears when a mission starts.
// - Cold flag sets at or below low threshold, hot flag at or above high threshold.
// - Writing mission active to 0 ends the mission; a write never sets it.
package lmcr_pkg;
  localparam logic [11:0] ADDR_COLD_THR = 12'h20b;
  localparam logic [11:0] ADDR_HOT_THR = 12'h20c;
  localparam logic [11:0] ADDR_INTERVAL = 12'h20d;
  localparam logic [11:0] ADDR_SETUP = 12'h20e;
  localparam logic [11:0] ADDR_DELAY_LO = 12'h212;
  localparam logic [11:0] ADDR_DELAY_HI = 12'h213;
  localparam logic [11:0] ADDR_STATUS = 12'h214;
  localparam logic [11:0] ADDR_RANGE_LO = 12'h200;
  localparam logic [11:0] ADDR_RANGE_HI = 12'h213;

  // Control byte fields.
  localparam int SB_OSC_STOP = 7;
  localparam int SB_WIPE = 6;
  localparam int SB_ARM_N = 4;
  localparam int SB_WRAP = 3;
  localparam int SB_COLD_S = 2;
  localparam int SB_HOT_S = 1;
  localparam int SB_TIMER_S = 0;
  localparam logic [7:0] SETUP_WR_MASK = 8'hdf;

  // Status byte fields.
  localparam int ST_IDLE_N = 7;
  localparam int ST_WIPED = 6;
  localparam int ST_MISSION = 5;
  localparam int ST_SAMPLE = 4;
  localparam int ST_COLD = 2;
  localparam int ST_HOT = 1;
  localparam int ST_TIMER = 0;

  // Reset values: oscillator stopped, missions disarmed.
  localparam logic [7:0] SETUP_RST = 8'h90;
  localparam logic [7:0] THR_RST = 8'h00;
  localparam logic [7:0] INTERVAL_RST = 8'h00;
  localparam logic [15:0] DELAY_RST = 16'h0000;

  typedef enum logic [1:0] {LMCR_IDLE, LMCR_DELAY, LMCR_LOG} lmcr_phase_e;
endpackage : lmcr_pkg

/* hdl/lmcr_mission_regs.sv */
// Mission configuration and status register set with mission sequencing.
module lmcr_mission_regs
  import lmcr_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Register access from the command engine
  input wire logic [11:0] regAddr,
  input wire logic regWr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  // Memory function commands
  input wire logic memFuncCmd,
  input wire logic memFuncIsClear,
  input wire logic otherAccess,
  output logic wipeMemory,
  // Timebase from the real-time clock
  input wire logic secondTick,
  input wire logic minuteTick,
  input wire logic timerAlarm,
  output logic oscRun,
  output logic retention,
  // Temperature converter and log memory
  input wire logic convBusy,
  input wire logic sampleBusy,
  input wire logic measValid,
  input wire logic [7:0] measTemp,
  input wire logic logFull,
  output logic sampleReq,
  output logic logStore,
  output logic logRestart,
  output logic histUpdate,
  // Search and mission state
  output logic searchMatch,
  output logic missionActive
);

  typedef struct packed {
    logic [7:0] coldThr;
    logic [7:0] hotThr;
    logic [7:0] interval;
    logic [7:0] setup;
    logic [15:0] delay;
    logic wiped;
    logic mission;
    logic coldF;
    logic hotF;
    logic timerF;
    logic rtcAdv;
    logic wipeArmed;
    lmcr_phase_e phase;
    logic [15:0] delayCnt;
    logic [7:0] intCnt;
    logic [7:0] rdData;
    logic sampleReq;
    logic logStore;
    logic logRestart;
    logic histUpdate;
    logic wipePulse;
    logic searchMatch;
    logic oscRun;
    logic retention;
  } lmcr_state_s;

  lmcr_state_s state_q;
  lmcr_state_s state_d;

  logic wrInRange;
  logic startMission;
  logic endMission;
  logic [7:0] statusByte;

  always_comb begin
    state_d = state_q;
    state_d.sampleReq = 1'b0;
    state_d.logStore = 1'b0;
    state_d.logRestart = 1'b0;
    state_d.histUpdate = 1'b0;
    state_d.wipePulse = 1'b0;

    statusByte = 8'h00;
    statusByte[ST_IDLE_N] = ~convBusy;
    statusByte[ST_WIPED] = state_q.wiped;
    statusByte[ST_MISSION] = state_q.mission;
    statusByte[ST_SAMPLE] = sampleBusy;
    statusByte[ST_COLD] = state_q.coldF;
    statusByte[ST_HOT] = state_q.hotF;
    statusByte[ST_TIMER] = state_q.timerF; // bit 3 stays 0

    wrInRange = regWr && (regAddr >= ADDR_RANGE_LO) && (regAddr <= ADDR_RANGE_HI);

    // A nonzero interval write with wiped memory, arm bit low and a running clock starts.
    startMission = regWr && (regAddr == ADDR_INTERVAL) && (regWrData != 8'h00)
      && state_q.wiped
      && !state_q.setup[SB_ARM_N]
      && state_q.rtcAdv
      && !state_q.mission;

    // Any write into the register page while a mission runs ends it.
    endMission = state_q.mission && (wrInRange
      || (regWr && (regAddr == ADDR_STATUS) && !regWrData[ST_MISSION]));

    // Register writes.
    if (regWr) begin
      unique case (regAddr)
        ADDR_COLD_THR: state_d.coldThr = regWrData;
        ADDR_HOT_THR: state_d.hotThr = regWrData;
        ADDR_INTERVAL: state_d.interval = regWrData;
        ADDR_SETUP: state_d.setup = regWrData & SETUP_WR_MASK;
        ADDR_DELAY_LO: state_d.delay[7:0] = regWrData;
        ADDR_DELAY_HI: state_d.delay[15:8] = regWrData;
        ADDR_STATUS: begin
          // Flags can only be written to 0; a write of 1 leaves them alone.
          if (!regWrData[ST_COLD]) begin
            state_d.coldF = 1'b0;
          end
          if (!regWrData[ST_HOT]) begin
            state_d.hotF = 1'b0;
          end
          if (!regWrData[ST_TIMER]) begin
            state_d.timerF = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // One second must elapse on a running oscillator before a start is accepted.
    if (state_q.setup[SB_OSC_STOP]) begin
      state_d.rtcAdv = 1'b0;
    end else if (secondTick) begin
      state_d.rtcAdv = 1'b1;
    end
    state_d.oscRun = !state_d.setup[SB_OSC_STOP];
    state_d.retention = state_d.setup[SB_OSC_STOP];

    // The wipe is armed only when the enable bit is written and nothing else intervenes.
    if (regWr && (regAddr == ADDR_SETUP)) begin
      state_d.wipeArmed = regWrData[SB_WIPE];
    end else if (otherAccess || regWr) begin
      state_d.wipeArmed = 1'b0;
    end
    if (memFuncCmd) begin
      state_d.setup[SB_WIPE] = 1'b0;
      state_d.wipeArmed = 1'b0;
      if (memFuncIsClear && state_q.wipeArmed && state_q.setup[SB_WIPE]) begin
        state_d.wipePulse = 1'b1;
        state_d.wiped = 1'b1;
        state_d.interval = INTERVAL_RST;
        state_d.delay = DELAY_RST;
      end
    end

    // Mission sequencing.
    if (startMission) begin
      state_d.mission = 1'b1;
      state_d.wiped = 1'b0;
      state_d.phase = LMCR_DELAY;
      state_d.delayCnt = state_q.delay;
      state_d.intCnt = 8'h00;
    end else if (endMission) begin
      state_d.mission = 1'b0;
      state_d.phase = LMCR_IDLE;
    end else begin
      unique case (state_q.phase)
        LMCR_IDLE: begin
        end
        LMCR_DELAY: begin
          if (minuteTick) begin
            if (state_q.delayCnt == 16'h0000) begin
              state_d.phase = LMCR_LOG;
              state_d.sampleReq = 1'b1;
              state_d.intCnt = state_q.interval - 8'h01;
            end else begin
              state_d.delayCnt = state_q.delayCnt - 16'h0001;
            end
          end
        end
        LMCR_LOG: begin
          if (minuteTick) begin
            if (state_q.intCnt == 8'h00) begin
              state_d.sampleReq = 1'b1;
              state_d.intCnt = state_q.interval - 8'h01;
            end else begin
              state_d.intCnt = state_q.intCnt - 8'h01;
            end
          end
        end
      endcase
    end

    // Sample results: flags set after any write clear, so a set wins.
    if (measValid && state_q.mission && (state_q.phase == LMCR_LOG)) begin
      state_d.histUpdate = 1'b1;
      if (!logFull) begin
        state_d.logStore = 1'b1;
      end else if (state_q.setup[SB_WRAP]) begin
        state_d.logStore = 1'b1;
        state_d.logRestart = 1'b1;
      end
      if (measTemp <= state_q.coldThr) begin
        state_d.coldF = 1'b1;
      end
      if (measTemp >= state_q.hotThr) begin
        state_d.hotF = 1'b1;
      end
    end
    if (timerAlarm) begin
      state_d.timerF = 1'b1;
    end

    state_d.searchMatch = (state_d.setup[SB_COLD_S] && state_d.coldF)
      || (state_d.setup[SB_HOT_S] && state_d.hotF)
      || (state_d.setup[SB_TIMER_S] && state_d.timerF);

    // Registered read path; unmapped addresses read zero.
    unique case (regAddr)
      ADDR_COLD_THR: state_d.rdData = state_q.coldThr;
      ADDR_HOT_THR: state_d.rdData = state_q.hotThr;
      ADDR_INTERVAL: state_d.rdData = state_q.interval;
      ADDR_SETUP: state_d.rdData = state_q.setup & SETUP_WR_MASK;
      ADDR_DELAY_LO: state_d.rdData = state_q.delay[7:0];
      ADDR_DELAY_HI: state_d.rdData = state_q.delay[15:8];
      ADDR_STATUS: state_d.rdData = statusByte;
      default: state_d.rdData = 8'h00;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state_q <= '0;
      state_q.coldThr <= THR_RST;
      state_q.hotThr <= THR_RST;
      state_q.interval <= INTERVAL_RST;
      state_q.setup <= SETUP_RST;
      state_q.delay <= DELAY_RST;
      state_q.phase <= LMCR_IDLE;
      state_q.retention <= 1'b1;
    end else begin
      state_q <= state_d;
    end
  end

  assign regRdData = state_q.rdData;
  assign wipeMemory = state_q.wipePulse;
  assign oscRun = state_q.oscRun;
  assign retention = state_q.retention;
  assign sampleReq = state_q.sampleReq;
  assign logStore = state_q.logStore;
  assign logRestart = state_q.logRestart;
  assign histUpdate = state_q.histUpdate;
  assign searchMatch = state_q.searchMatch;
  assign missionActive = state_q.mission;

endmodule // lmcr_mission_regs

/* tb/lmcr_conv_model.sv */
// Behavioural temperature converter answering mission sample requests.
module lmcr_conv_model (
  // Clock and requests
  input wire logic mclk,
  input wire logic sampleReq,
  input wire logic [7:0] tempIn,
  // Converter state and result
  output logic convBusy,
  output logic sampleBusy,
  output logic measValid,
  output logic [7:0] measTemp
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] cnt = 3'h0;
  initial begin
    measValid = 1'b0;
    measTemp = 8'h00;
  end
  // The result lines toggle outside a valid pulse so stale data is never mistaken.
  always @(posedge mclk) begin
    measValid <= (cnt == 3'h1);
    measTemp <= (cnt == 3'h1) ? tempIn : ~measTemp;
    if (sampleReq) begin
      cnt <= 3'h4;
    end else if (cnt != 3'h0) begin
      cnt <= cnt - 3'h1;
    end
  end
  assign convBusy = (cnt != 3'h0);
  assign sampleBusy = convBusy;
endmodule // lmcr_conv_model

/* tb/lmcr_mission_regs_monitor.sv */
// Concurrent checks on the ports of the mission register set.
module lmcr_mission_regs_monitor
  import lmcr_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Register access
  input wire logic [11:0] regAddr,
  input wire logic regWr,
  input wire logic [7:0] regWrData,
  input wire logic [7:0] regRdData,
  // Commands and events
  input wire logic memFuncCmd,
  input wire logic memFuncIsClear,
  input wire logic minuteTick,
  input wire logic measValid,
  input wire logic logFull,
  // Watched outputs
  input wire logic wipeMemory,
  input wire logic oscRun,
  input wire logic retention,
  input wire logic sampleReq,
  input wire logic logStore,
  input wire logic logRestart,
  input wire logic histUpdate,
  input wire logic missionActive
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);
  a_osc_follows_setup: assert property (regWr && regAddr == ADDR_SETUP |=>
    retention == $past(regWrData[SB_OSC_STOP]) && oscRun != retention)
    else $error("oscillator state differs from control write");
  a_wipe_cause: assert property (wipeMemory |-> $past(memFuncCmd) && $past(memFuncIsClear))
    else $error("wipe without clear command");
  a_wipe_single: assert property (wipeMemory |=> !wipeMemory)
    else $error("wipe pulse too long");
  a_page_write_ends: assert property (missionActive && regWr && regAddr >= ADDR_RANGE_LO
    && regAddr <= ADDR_RANGE_HI |=> !missionActive)
    else $error("mission survived page write");
  a_status_clear_ends: assert property (regWr && regAddr == ADDR_STATUS
    && !regWrData[ST_MISSION] |=> !missionActive)
    else $error("mission survived status clear");
  a_start_cause: assert property ($rose(missionActive) |-> $past(regWr)
    && $past(regAddr) == ADDR_INTERVAL && $past(regWrData) != 8'h00)
    else $error("mission started without interval write");
  a_sample_on_tick: assert property (sampleReq |-> $past(minuteTick) && $past(missionActive))
    else $error("sample request without minute tick");
  a_hist_cause: assert property (histUpdate |-> $past(measValid) && $past(missionActive))
    else $error("histogram update without sample");
  a_store_rules: assert property (logStore |-> histUpdate && (!$past(logFull) || logRestart))
    else $error("log store while full without wrap");
  a_restart_full: assert property (logRestart |-> logStore && $past(logFull))
    else $error("log restart while not full");
  a_bit5_zero: assert property (regAddr == ADDR_SETUP |=> regRdData[5] == 1'b0)
    else $error("control bit 5 reads one");
endmodule // lmcr_mission_regs_monitor

bind lmcr_mission_regs lmcr_mission_regs_monitor u_mon (
  .mclk(mclk),
  .srst(srst),
  .regAddr(regAddr),
  .regWr(regWr),
  .regWrData(regWrData),
  .regRdData(regRdData),
  .memFuncCmd(memFuncCmd),
  .memFuncIsClear(memFuncIsClear),
  .minuteTick(minuteTick),
  .measValid(measValid),
  .logFull(logFull),
  .wipeMemory(wipeMemory),
  .oscRun(oscRun),
  .retention(retention),
  .sampleReq(sampleReq),
  .logStore(logStore),
  .logRestart(logRestart),
  .histUpdate(histUpdate),
  .missionActive(missionActive)
);

/* tb/tb.sv */
// Directed testbench for the mission register set.
module tb;
  import lmcr_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic [11:0] regAddr = 12'h000;
  logic regWr = 1'b0;
  logic [7:0] regWrData = 8'h00;
  logic memFuncCmd = 1'b0, otherAccess = 1'b0, secondTick = 1'b0, minuteTick = 1'b0;
  logic timerAlarm = 1'b0, memFuncIsClear = 1'b1, logFull = 1'b0;
  logic [7:0] tempIn = 8'h10;
  logic [7:0] regRdData, measTemp;
  logic wipeMemory, oscRun, retention, convBusy, sampleBusy, measValid, sampleReq;
  logic logStore, logRestart, histUpdate, searchMatch, missionActive;
  int mismatches = 0;
  int checks = 0;
  logic [7:0] histCount = 8'h00;
  logic [7:0] storeCount = 8'h00;
  logic [7:0] restartCount = 8'h00;
  always #50 mclk = ~mclk;
  lmcr_mission_regs DUT (
    .mclk(mclk),
    .srst(srst),
    .regAddr(regAddr),
    .regWr(regWr),
    .regWrData(regWrData),
    .regRdData(regRdData),
    .memFuncCmd(memFuncCmd),
    .memFuncIsClear(memFuncIsClear),
    .otherAccess(otherAccess),
    .wipeMemory(wipeMemory),
    .secondTick(secondTick),
    .minuteTick(minuteTick),
    .timerAlarm(timerAlarm),
    .oscRun(oscRun),
    .retention(retention),
    .convBusy(convBusy),
    .sampleBusy(sampleBusy),
    .measValid(measValid),
    .measTemp(measTemp),
    .logFull(logFull),
    .sampleReq(sampleReq),
    .logStore(logStore),
    .logRestart(logRestart),
    .histUpdate(histUpdate),
    .searchMatch(searchMatch),
    .missionActive(missionActive)
  );
  lmcr_conv_model u_conv (
    .mclk(mclk),
    .sampleReq(sampleReq),
    .tempIn(tempIn),
    .convBusy(convBusy),
    .sampleBusy(sampleBusy),
    .measValid(measValid),
    .measTemp(measTemp)
  );
  // Result pulses are counted in mid-cycle, where they have settled.
  always @(negedge mclk) begin
    if (histUpdate === 1'b1) begin
      histCount <= histCount + 8'h01;
    end
    if (logStore === 1'b1) begin
      storeCount <= storeCount + 8'h01;
    end
    if (logRestart === 1'b1) begin
      restartCount <= restartCount + 8'h01;
    end
  end
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, s);
      mismatches++;
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge mclk) begin
      regAddr <= a;
      regWr <= 1'b1;
      regWrData <= d;
    end
    @(posedge mclk) regWr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge mclk) regAddr <= a;
    @(posedge mclk);
    @(negedge mclk) chk($sformatf("reg %h", a), regRdData, e);
  endtask
  // Pulses {timerAlarm, memFuncCmd, otherAccess, secondTick, minuteTick} for one cycle.
  task automatic go(input logic [4:0] k);
    @(posedge mclk) {timerAlarm, memFuncCmd, otherAccess, secondTick, minuteTick} <= k;
    @(posedge mclk) {timerAlarm, memFuncCmd, otherAccess, secondTick, minuteTick} <= 5'h00;
    @(negedge mclk);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge mclk);
    srst <= 1'b0;
    rd(ADDR_SETUP, 8'h90);
    rd(ADDR_STATUS, 8'h80);
    rd(12'h215, 8'h00);
    chk("retention", {7'h00, retention}, 8'h01);
    wr(ADDR_SETUP, 8'hff);
    rd(ADDR_SETUP, 8'hdf);
    wr(ADDR_COLD_THR, 8'h20);
    wr(ADDR_HOT_THR, 8'hf0);
    rd(ADDR_COLD_THR, 8'h20);
    rd(ADDR_HOT_THR, 8'hf0);
    $display("reset and access test done");
    wr(ADDR_SETUP, 8'h40);
    rd(ADDR_SETUP, 8'h40);
    chk("oscRun", {7'h00, oscRun}, 8'h01);
    go(5'h04);
    go(5'h08);
    chk("wipeMemory", {7'h00, wipeMemory}, 8'h00);
    rd(ADDR_SETUP, 8'h00);
    wr(ADDR_SETUP, 8'h44);
    go(5'h08);
    chk("wipeMemory", {7'h00, wipeMemory}, 8'h01);
    rd(ADDR_SETUP, 8'h04);
    rd(ADDR_STATUS, 8'hc0);
    $display("wipe test done");
    wr(ADDR_DELAY_LO, 8'h01);
    wr(ADDR_DELAY_HI, 8'h00);
    rd(ADDR_DELAY_LO, 8'h01);
    go(5'h10);
    wr(ADDR_INTERVAL, 8'h02);
    rd(ADDR_STATUS, 8'hc1);
    go(5'h02);
    wr(ADDR_INTERVAL, 8'h00);
    rd(ADDR_STATUS, 8'hc1);
    wr(ADDR_INTERVAL, 8'h02);
    rd(ADDR_STATUS, 8'ha1);
    for (int i = 0; i < 4; i++) begin
      go(5'h01);
      chk("sampleReq", {7'h00, sampleReq}, {7'h00, i[0]});
    end
    // The first sample lands with free log space, the second after the log has filled.
    repeat (3) @(posedge mclk);
    logFull <= 1'b1;
    repeat (7) @(posedge mclk);
    chk("histCount", histCount, 8'h02);
    chk("storeCount", storeCount, 8'h01);
    chk("restartCount", restartCount, 8'h00);
    rd(ADDR_STATUS, 8'ha5);
    chk("searchMatch", {7'h00, searchMatch}, 8'h01);
    wr(ADDR_STATUS, 8'hff);
    rd(ADDR_STATUS, 8'ha5);
    wr(ADDR_SETUP, 8'h04);
    rd(ADDR_STATUS, 8'h85);
    wr(ADDR_STATUS, 8'h00);
    rd(ADDR_STATUS, 8'h80);
    $display("mission test done");
    report_and_stop;
  end
  initial begin
    repeat (3000) @(posedge mclk);
    mismatches++;
    report_and_stop;
  end
endmodule // tb
